// file: core/bp_pkg.sv
// Purpose: Shared constants for the backplane card slave and DMA handshake
// Assumes: 20 MHz clock, 50 ns period
// Notes: APB register map and timing counts live here
package bp_pkg;
  localparam int unsigned CLK_NS = 50;
  // Fast-acknowledge limits: times in ns, processor clock in MHz, access in cycles
  localparam int unsigned ACK_TURN_NS = 25;
  localparam int unsigned DATA_AS_NS = 265;
  localparam int unsigned DATA_ADDR_NS = 295;
  localparam int unsigned PROC_CLK_MHZ = 8;
  localparam int unsigned FAST_CYCLES = 5;
  // Longest times round down, never below one cycle
  localparam int unsigned DATA_AS_CYC =
    (DATA_AS_NS / CLK_NS) > 0 ? DATA_AS_NS / CLK_NS : 1;
  localparam int unsigned DATA_ADDR_CYC =
    (DATA_ADDR_NS / CLK_NS) > 0 ? DATA_ADDR_NS / CLK_NS : 1;
  // Read data must be ready by the longer of both limits
  localparam int unsigned DATA_CYC =
    DATA_AS_CYC > DATA_ADDR_CYC ? DATA_AS_CYC : DATA_ADDR_CYC;
  localparam int unsigned GRANT_TMO_NS = 2500;
  localparam int unsigned GRANT_TMO_CYC = GRANT_TMO_NS / CLK_NS;
  // APB map, byte addresses
  localparam logic [7:0] REG_DMA_EN = 8'h0c; // write register 3
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_WDATA = 8'h18;
  localparam logic [7:0] REG_RDATA = 8'h1c;
  localparam int unsigned EN0_BIT = 0;
  localparam int unsigned EN1_BIT = 1;
  localparam int unsigned BYTE_MODE_BIT = 2;
  localparam int unsigned DIR_IN_BIT = 3;
  localparam int unsigned MEM_AW = 6;
  localparam int unsigned DW = 16;
endpackage

// file: core/bp_sync.sv
// Purpose: Two-flop synchroniser for backplane pins
// Assumes: Inputs are asynchronous to clk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module bp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  // Two stages, first read only by second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // bp_sync

// file: core/bp_mem.sv
// Purpose: Small on-card memory served over the backplane
// Assumes: One write port, one registered read port
// Notes: Fixed access time suits the fast-acknowledge path
`timescale 1ns/1ps
module bp_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // Registered read keeps data output on a flop
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule // bp_mem

// file: core/bp_card.sv
// Purpose: Card-side backplane slave with fast ack and two DMA channels
// Assumes: 20 MHz clk; backplane pins synchronised on entry, except the raw pins that gate fast ack
// Notes: Fast ack is combinational from the enable pin to meet 25 ns
//
// Contract
// - Fast-acknowledge memory access completes in five 8 MHz cycles.
// - Slave asserts transfer-ack within 25 ns of enable going active.
// - Fast read data valid within 265 ns of address strobe.
// - Fast read data valid within 295 ns of address; longer applies.
// - Ack may precede read data; master accepts later data.
// - Card never performs read-modify-write cycles.
// - Two identical DMA channels, each with own request and grant.
// - Card requests DMA only after software writes write register 3.
// - Card treats channel grant like address strobe, starts transfer.
// - Card asserts ready after supplying or accepting data.
// - During DMA card handshakes only through grant and ready. Transfer-ack pins are not gated by grant.
// - Word mode moves one full word per DMA cycle.
// - Byte mode card uses only lower data byte.
// - Controller drives fold indicator; card ignores it.
// - Controller drives completion; card may use it.
// - Card holds ready until grant removed, then drops ready.
// - Ready missing 2.5 us after grant ends transfer with bus error.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module bp_card
  import bp_pkg::*;
#(
  parameter int unsigned AW = bp_pkg::MEM_AW,
  parameter int unsigned TMO_CYC = bp_pkg::GRANT_TMO_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backplane slave pins
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write_select,
  input wire logic card_select,
  input wire logic [bp_pkg::MEM_AW-1:0] bus_addr,
  input wire logic early_ack_enable_n,
  output logic transfer_ack_n,
  output logic transfer_ack_oe,
  input wire logic [bp_pkg::DW-1:0] data_in,
  output logic [bp_pkg::DW-1:0] data_out,
  output logic data_oe,
  // DMA handshake pins
  output logic xfer_request_ch0_n,
  output logic xfer_request_ch1_n,
  input wire logic xfer_grant_ch0_n,
  input wire logic xfer_grant_ch1_n,
  output logic card_ready_n,
  output logic card_ready_oe,
  input wire logic dma_done_n,
  output logic bus_error_seen
);
  import bp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic as_n_s, ds_n_s, rw_s, cs_s, g0_n_s, g1_n_s, done_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] din_s;

  // Idle levels: strobes, grants and done high, read high, select low
  bp_sync #(.W(7), .INIT(7'h77)) u_sync_ctl (
    .clk(clk),
    .rst(rst),
    .din({address_strobe_n, data_strobe_n, read_write_select, card_select,
          xfer_grant_ch0_n, xfer_grant_ch1_n, dma_done_n}),
    .dout({as_n_s, ds_n_s, rw_s, cs_s, g0_n_s, g1_n_s, done_n_s})
  );

  bp_sync #(.W(AW + DW), .INIT('0)) u_sync_dat (
    .clk(clk),
    .rst(rst),
    .din({bus_addr, data_in}),
    .dout({addr_s, din_s})
  );

  //////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [1:0] dma_en_r;
  logic byte_mode_r, dir_in_r;
  logic [DW-1:0] sw_wdata_r, sw_rdata_r;
  logic [31:0] prdata_r;
  logic wr_acc, rd_acc, addr_ok;

  // APB answers in the access phase with no wait
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign addr_ok = (paddr == REG_DMA_EN) || (paddr == REG_CTRL) ||
                   (paddr == REG_STATUS) || (paddr == REG_WDATA) ||
                   (paddr == REG_RDATA);
  assign pslverr = psel && penable && !addr_ok;

  // Write decode; channel enables gate request logic
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dma_en_r <= 2'h0;
      byte_mode_r <= 1'b0;
      dir_in_r <= 1'b0;
      sw_wdata_r <= '0;
    end
    else if (wr_acc)
    begin
      if (paddr == REG_DMA_EN)
        dma_en_r <= pwdata[EN1_BIT:EN0_BIT];
      if (paddr == REG_CTRL)
      begin
        byte_mode_r <= pwdata[BYTE_MODE_BIT];
        dir_in_r <= pwdata[DIR_IN_BIT];
      end
      if (paddr == REG_WDATA)
        sw_wdata_r <= pwdata[DW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // DMA channel handshake
  typedef enum logic [1:0] {D_IDLE, D_XFER, D_READY, D_WAIT} dma_st_t;
  dma_st_t dst_r, dst_nxt;
  logic [1:0] grant;
  logic any_grant, grant_seen, cyc_done;
  logic [15:0] tmo_r;
  logic bus_err_r, done_seen_r;
  logic ready_r;
  logic [DW-1:0] dma_out_r;

  // Both channels share one data path; they behave identically
  assign grant = {!g1_n_s, !g0_n_s};
  assign any_grant = |(grant & dma_en_r);
  // Release follows the pin alone, so a late disable cannot cut ready short
  assign grant_seen = |grant;
  // Fold indicator is not taken in; the byte lane stays fixed low

  always_comb
  begin
    dst_nxt = dst_r;
    unique case (dst_r)
      D_IDLE: if (any_grant) dst_nxt = D_XFER;
      // One cycle to take or place data, then ready
      D_XFER: dst_nxt = D_READY;
      D_READY: if (cyc_done) dst_nxt = D_WAIT;
      D_WAIT: dst_nxt = D_IDLE;
    endcase
  end

  assign cyc_done = (dst_r == D_READY) && !grant_seen;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dst_r <= D_IDLE;
      ready_r <= 1'b0;
      dma_out_r <= '0;
      sw_rdata_r <= '0;
      done_seen_r <= 1'b0;
    end
    else
    begin
      dst_r <= dst_nxt;
      ready_r <= (dst_nxt == D_READY);
      if (dst_r == D_XFER)
      begin
        // Byte mode keeps to the low lane only
        if (byte_mode_r)
          dma_out_r <= {{(DW-8){1'b0}}, sw_wdata_r[7:0]};
        else
          dma_out_r <= sw_wdata_r;
        if (!dir_in_r)
          sw_rdata_r <= byte_mode_r ? {{(DW-8){1'b0}}, din_s[7:0]} : din_s;
      end
      // Completion flag is optional help; set wins over clear
      if (!done_n_s)
        done_seen_r <= 1'b1;
      else if (wr_acc && paddr == REG_STATUS)
        done_seen_r <= 1'b0;
    end
  end

  // Watchdog mirrors the controller's bus-error window for status
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tmo_r <= '0;
      bus_err_r <= 1'b0;
    end
    else
    begin
      // Counts while granted but not ready; trips on a grant never served
      if (!grant_seen || ready_r)
        tmo_r <= '0;
      else if (tmo_r < 16'(TMO_CYC))
        tmo_r <= tmo_r + 16'h0001;
      if (grant_seen && !ready_r && tmo_r >= 16'(TMO_CYC))
        bus_err_r <= 1'b1;
      else if (wr_acc && paddr == REG_STATUS)
        bus_err_r <= 1'b0;
    end
  end
  assign bus_error_seen = bus_err_r;

  // Request only when enabled and idle
  assign xfer_request_ch0_n = !(dma_en_r[0] && dst_r == D_IDLE);
  assign xfer_request_ch1_n = !(dma_en_r[1] && dst_r == D_IDLE);
  // Ready is driven low only while asserted; pull-up elsewhere
  assign card_ready_n = !ready_r;
  assign card_ready_oe = ready_r;

  //////////////////////////////////////////////////////////////////////////
  // Fast-acknowledge slave
  logic sel_cyc;
  logic [2:0] acc_cnt_r;
  logic [DW-1:0] mem_q;
  logic mem_we;

  // Strobe-based cycles only when no DMA grant is active
  assign sel_cyc = !as_n_s && cs_s && !any_grant;
  assign mem_we = sel_cyc && !ds_n_s && !rw_s && acc_cnt_r == 3'h1;

  bp_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(addr_s),
    .wdata(din_s),
    .raddr(addr_s),
    .rdata(mem_q)
  );

  // Count cycles into the access; read data is registered early
  always_ff @(posedge clk)
  begin
    if (rst)
      acc_cnt_r <= 3'h0;
    else if (!sel_cyc)
      acc_cnt_r <= 3'h0;
    else if (acc_cnt_r != 3'h7)
      acc_cnt_r <= acc_cnt_r + 3'h1;
  end

  // Ack from enable is pure gating: no flop in the 25 ns path
  assign transfer_ack_n = !(card_select && !address_strobe_n &&
                            !early_ack_enable_n);
  assign transfer_ack_oe = card_select && !address_strobe_n;
  // Data sits on the bus from the third clock, well before DATA_CYC
  assign data_oe = (sel_cyc && rw_s) || (ready_r && dir_in_r);
  assign data_out = ready_r ? dma_out_r : mem_q;
  // This card never issues locked read-modify-write cycles

  //////////////////////////////////////////////////////////////////////////
  // Read back
  logic [31:0] rd_mux;
  assign rd_mux =
    (paddr == REG_DMA_EN) ? {30'h0, dma_en_r} :
    (paddr == REG_CTRL) ? {28'h0, dir_in_r, byte_mode_r, 2'h0} :
    (paddr == REG_STATUS) ? {28'h0, done_seen_r, bus_err_r,
                             dst_r != D_IDLE, ready_r} :
    (paddr == REG_WDATA) ? {16'h0, sw_wdata_r} :
    (paddr == REG_RDATA) ? {16'h0, sw_rdata_r} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_r <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata_r <= rd_mux;
  end
  assign prdata = prdata_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_req_gated_en: assert property (@(posedge clk) disable iff (rst)
    !dma_en_r[0] |-> xfer_request_ch0_n)
    else $error("request without enable");
  a_req_drop_dis: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == REG_DMA_EN && !pwdata[EN1_BIT]) |=>
    xfer_request_ch1_n)
    else $error("request stayed after disable");
  sequence s_grant_rise;
    (dst_r == D_IDLE) && any_grant;
  endsequence
  a_ready_after_grant: assert property (@(posedge clk) disable iff (rst)
    s_grant_rise |-> ##2 !card_ready_n)
    else $error("ready late after grant");
  a_ready_hold: assert property (@(posedge clk) disable iff (rst)
    (ready_r && grant_seen) |=> ready_r)
    else $error("ready dropped while granted");
  a_ready_release: assert property (@(posedge clk) disable iff (rst)
    (ready_r && !grant_seen) |=> !ready_r)
    else $error("ready held after grant gone");
  a_fast_ack: assert property (@(posedge clk) disable iff (rst)
    (card_select && !address_strobe_n && !early_ack_enable_n) |->
    !transfer_ack_n)
    else $error("no ack on enable");
  a_byte_lane: assert property (@(posedge clk) disable iff (rst)
    (byte_mode_r && ready_r) |-> dma_out_r[DW-1:8] == '0)
    else $error("upper lane used in byte mode");
  a_read_data_by: assert property (@(posedge clk) disable iff (rst)
    $rose(sel_cyc && rw_s) |-> ##[1:5] data_oe)
    else $error("read data late");
  a_dma_no_strobe: assert property (@(posedge clk) disable iff (rst)
    any_grant |-> !sel_cyc)
    else $error("strobe path used during grant");
endmodule // bp_card

// file: verification/dma_ctl_model.sv
// Purpose: Behavioural DMA controller on the far side of the card
// Assumes: Grant and done lines are active low and pulled up when idle
// Notes: Handshake slips are counted in viol for the bench to judge
`timescale 1ns/1ps
module dma_ctl_model #(
  parameter logic [15:0] PAT = 16'h5a3c,
  parameter int GAP = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req0_n,
  input wire logic req1_n,
  input wire logic ready_n,
  input wire logic [15:0] dbus,
  input wire logic [31:0] limit,
  output logic grant0_n,
  output logic grant1_n,
  output logic done_n,
  output logic [15:0] drive,
  output logic [15:0] last,
  output logic lch,
  output int cnt,
  output int viol
);
  int n;
  logic act = 1'b0;
  ////////////////////////////////////////
  // Memory data only while a cycle runs; inverts each clock otherwise, so a stale PAT lasts one cycle
  always @(posedge clk)
    drive <= act ? PAT : ~drive;
  ////////////////////////////////////////
  // One bus cycle per request, channel 0 first; fold line is not modelled
  initial
  begin
    grant0_n = 1'b1;
    grant1_n = 1'b1;
    done_n = 1'b1;
    drive = 16'h0000;
    cnt = 0;
    viol = 0;
    forever
    begin
      @(posedge clk);
      if (!rst && cnt < limit && !(req0_n && req1_n))
      begin
        lch <= req0_n;
        act <= 1'b1;
        repeat (GAP) @(posedge clk);
        done_n <= (cnt + 1 >= limit) ? 1'b0 : 1'b1;
        if (lch)
          grant1_n <= 1'b0;
        else
          grant0_n <= 1'b0;
        n = 0;
        while (ready_n !== 1'b0 && n < 100)
        begin
          @(posedge clk);
          n++;
        end
        if (ready_n !== 1'b0)
          viol++;
        last <= dbus;
        cnt <= cnt + 1;
        repeat (GAP)
        begin
          @(posedge clk);
          if (ready_n !== 1'b0)
            viol++;
        end
        // Bus given up after every cycle, the slowest legal choice
        grant0_n <= 1'b1;
        grant1_n <= 1'b1;
        done_n <= 1'b1;
        act <= 1'b0;
        n = 0;
        while (ready_n !== 1'b1 && n < 8)
        begin
          @(posedge clk);
          n++;
        end
        if (ready_n !== 1'b1)
          viol++;
      end
    end
  end
endmodule // dma_ctl_model

// file: verification/tb.sv
// Purpose: Self-checking bench for the backplane card
// Assumes: 20 MHz clk, synchronous active-high reset
// Notes: Short grant watchdog keeps the run brief
`timescale 1ns/1ps
module tb;
  import bp_pkg::*;
  localparam logic [15:0] PAT = 16'h5a3c;
  localparam logic [31:0] DIN = 32'h1 << DIR_IN_BIT;
  localparam logic [31:0] BYT = 32'h1 << BYTE_MODE_BIT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic address_strobe_n = 1'b1;
  logic data_strobe_n = 1'b1;
  logic read_write_select = 1'b1;
  logic card_select = 1'b0;
  logic [5:0] bus_addr = 6'h00;
  logic early_ack_enable_n = 1'b1;
  logic [31:0] q;
  logic e;
  logic [15:0] last;
  logic lch;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int lim = 1000;
  int cnt, viol;
  wire logic [31:0] prdata;
  wire logic [15:0] data_in, data_out;
  wire logic pready, pslverr, transfer_ack_n, transfer_ack_oe, data_oe;
  wire logic xfer_request_ch0_n, xfer_request_ch1_n, card_ready_n;
  wire logic card_ready_oe, bus_error_seen, dma_done_n;
  wire logic xfer_grant_ch0_n, xfer_grant_ch1_n;
  // Ready line pulled up; data bus carries the card only while it drives
  wire logic ready_w = card_ready_oe ? card_ready_n : 1'b1;
  wire logic [15:0] dbus = data_oe ? data_out : data_in;

  bp_card #(.TMO_CYC(10)) i_bp_card (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .address_strobe_n, .data_strobe_n,
    .read_write_select, .card_select, .bus_addr, .early_ack_enable_n,
    .transfer_ack_n, .transfer_ack_oe, .data_in, .data_out, .data_oe,
    .xfer_request_ch0_n, .xfer_request_ch1_n, .xfer_grant_ch0_n,
    .xfer_grant_ch1_n, .card_ready_n, .card_ready_oe, .dma_done_n,
    .bus_error_seen
  );
  dma_ctl_model #(.PAT(PAT)) i_dma_ctl_model (
    .clk, .rst, .req0_n(xfer_request_ch0_n), .req1_n(xfer_request_ch1_n),
    .ready_n(ready_w), .dbus, .limit(lim), .grant0_n(xfer_grant_ch0_n),
    .grant1_n(xfer_grant_ch1_n), .done_n(dma_done_n), .drive(data_in),
    .last, .lch, .cnt, .viol
  );

  always #25 clk = ~clk;
  ////////////////////////////////////////
  // Watchdog, plus no strobe handshake while a grant is out
  always @(posedge clk)
  begin
    cyc++;
    if (!(xfer_grant_ch0_n && xfer_grant_ch1_n) && transfer_ack_oe === 1'b1)
      chk(1, 0);
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b1, 8'h40, 32'hffff);
    chk(e, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, REG_CTRL, DIN | BYT);
    apb(1'b0, REG_CTRL, 32'h0);
    chk({e, q}, {1'b0, DIN | BYT});
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0);
  endtask

  task automatic t_idle();
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({xfer_request_ch1_n, xfer_request_ch0_n}, 2'b11);
  endtask

  task automatic t_fast();
    @(posedge clk);
    address_strobe_n <= 1'b0;
    data_strobe_n <= 1'b0;
    card_select <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(transfer_ack_n, 1'b1);
    @(posedge clk);
    early_ack_enable_n <= 1'b0;
    #25 chk({transfer_ack_oe, transfer_ack_n}, 2'b10);
    repeat (DATA_CYC - 4) @(posedge clk);
    #1 chk(data_oe, 1'b1);
    @(posedge clk);
    address_strobe_n <= 1'b1;
    data_strobe_n <= 1'b1;
    card_select <= 1'b0;
    early_ack_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({transfer_ack_oe, data_oe}, 2'b00);
  endtask

  task automatic t_dma(input logic ch, input logic [31:0] ctl,
    input logic [15:0] exp);
    int c0;
    int n;
    apb(1'b1, REG_CTRL, ctl);
    apb(1'b1, REG_WDATA, 32'h0000a5c3);
    c0 = cnt;
    apb(1'b1, REG_DMA_EN, 32'h1 << (ch ? EN1_BIT : EN0_BIT));
    @(negedge clk);
    chk({xfer_request_ch1_n, xfer_request_ch0_n}, {!ch, ch});
    n = 0;
    while (cnt == c0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    apb(1'b1, REG_DMA_EN, 32'h0);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk({xfer_request_ch1_n, xfer_request_ch0_n}, 2'b11);
    chk(cnt, c0 + 1);
    chk(lch, ch);
    if (ctl[DIR_IN_BIT])
      chk(last, exp);
    else
    begin
      apb(1'b0, REG_RDATA, 32'h0);
      chk(q, {16'h0, exp});
    end
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_idle();
    t_fast();
    t_dma(1'b0, DIN, 16'ha5c3);
    t_dma(1'b1, DIN | BYT, 16'h00c3);
    t_dma(1'b1, 32'h0, PAT);
    t_dma(1'b0, BYT, {8'h00, PAT[7:0]});
    lim <= cnt + 1;
    t_dma(1'b0, DIN, 16'ha5c3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h8, 32'h8);
    chk({bus_error_seen, 32'(viol)}, 33'h0);
    close_out();
  end
endmodule // tb
